// ### hw/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// ==========================================================
// Sizes
`define ACS_SET_N      8
`define ACS_SET_W      3
`define ACS_FEAT_N     4
`define ACS_FEAT_IW    2
`define ACS_FEAT_W     8
`define ACS_SRC_N      4
`define ACS_SRC_W      2

// ==========================================================
// Feature web: row i (4 bits at 4*i) lists what feature i depends on
`define ACS_DEP_MAP    16'h0802
`define ACS_AUTO_MASK  4'h5
`define ACS_FEAT_MAX   8'hf0
`define ACS_FEAT_RST   8'h00
`define ACS_PATH_ONLY  3'h0

// ==========================================================
// Reset values
`define ACS_IDX_RST    3'h0
`define ACS_SRC_RST    2'h0
`define ACS_MASK_RST   4'h0
`define ACS_VALID_RST  8'h00

`endif

// ### hw/acs_pkg.sv
`include "acs_defines.svh"

package acs_pkg;
  typedef logic [`ACS_FEAT_W-1:0]       acs_val_type;
  typedef acs_val_type [`ACS_FEAT_N-1:0] acs_vals_type;
  typedef logic [`ACS_SET_W-1:0]        acs_idx_type;
  typedef acs_idx_type [`ACS_SET_N-1:0] acs_nexts_type;
  typedef enum logic [1:0] {ACS_Q_RISE, ACS_Q_FALL, ACS_Q_HIGH, ACS_Q_LOW} acs_qual_type;
  typedef struct packed {
    logic [`ACS_SRC_W-1:0] src;
    acs_qual_type          qual;
    acs_idx_type           next;
  } acs_path_type;
  typedef enum logic [1:0] {ACS_ST_IDLE, ACS_ST_SETUP, ACS_ST_RUN} acs_state_type;
endpackage : acs_pkg

// ### hw/acs_store_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

interface acs_store_if;
  logic                    save_we;
  acs_pkg::acs_idx_type    save_idx;
  acs_pkg::acs_vals_type   save_vals;
  logic                    path_we;
  acs_pkg::acs_idx_type    path_idx;
  acs_pkg::acs_path_type   path_wr;
  acs_pkg::acs_idx_type    rd_idx;
  acs_pkg::acs_vals_type   rd_vals;
  acs_pkg::acs_idx_type    act_idx;
  acs_pkg::acs_path_type   act_path;
  acs_pkg::acs_nexts_type  all_next;
  acs_pkg::acs_vals_type   cur_vals;
  logic [`ACS_FEAT_N-1:0]  fix_mask;
  logic [`ACS_SET_N-1:0]   fix_match;

  modport owner (output save_we, save_idx, save_vals, path_we, path_idx, path_wr, rd_idx, act_idx,
                 cur_vals, fix_mask, input rd_vals, act_path, all_next, fix_match);
  modport store (input save_we, save_idx, save_vals, path_we, path_idx, path_wr, rd_idx, act_idx,
                 cur_vals, fix_mask, output rd_vals, act_path, all_next, fix_match);
endinterface : acs_store_if

`default_nettype wire

// ### hw/acs_set_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_set_store (
  input  wire logic   sys_clk,
  input  wire logic   reset_n,
  acs_store_if.store  st
);
  acs_pkg::acs_vals_type vals_q [`ACS_SET_N];
  acs_pkg::acs_vals_type vals_d [`ACS_SET_N];
  acs_pkg::acs_path_type path_q [`ACS_SET_N];
  acs_pkg::acs_path_type path_d [`ACS_SET_N];

  // ==========================================================
  // Set memory
  always_comb begin
    vals_d = vals_q;
    path_d = path_q;
    if (st.save_we) begin
      vals_d[st.save_idx] = st.save_vals;
    end
    if (st.path_we) begin
      path_d[st.path_idx] = st.path_wr;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `ACS_SET_N; i++) begin
        vals_q[i] <= '{default: `ACS_FEAT_RST};
        path_q[i] <= '{src: `ACS_SRC_RST, qual: acs_pkg::ACS_Q_RISE, next: `ACS_IDX_RST};
      end
    end else begin
      vals_q <= vals_d;
      path_q <= path_d;
    end
  end

  // ==========================================================
  // Read ports and fixed-value comparison
  assign st.rd_vals  = vals_q[st.rd_idx];
  assign st.act_path = path_q[st.act_idx];

  for (genvar g = 0; g < `ACS_SET_N; g++) begin : g_set
    logic [`ACS_FEAT_N-1:0] diff;
    for (genvar f = 0; f < `ACS_FEAT_N; f++) begin : g_feat
      assign diff[f] = st.fix_mask[f] && (vals_q[g][f] != st.cur_vals[f]);
    end
    assign st.all_next[g]  = path_q[g].next;
    assign st.fix_match[g] = ~|diff;
  end
endmodule : acs_set_store

`default_nettype wire

// ### hw/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

// Contract
// - Eight settings sets, each stored separately
// - Setup entry classifies features, locks fixed ones
// - Fixed values locked in setup and run
// - Implied features stored, editable, locked running
// - Automatic features forced off while running
// - Save captures all active settings
// - Non-sequenced features never touched
// - Set index selects save, load, path target
// - Save checks set, reports its validity
// - Save may invalidate other sets
// - Load valid set any time
// - Only path zero is usable
// - Path holds trigger source and qualifier
// - Path holds next set index
// - Starting set chosen before run begins
// - Setup exit checks whole configuration
// - Run locks, loads start; stop keeps settings

module acs_sequencer (
  input  wire logic                                  sys_clk,
  input  wire logic                                  reset_n,
  input  wire logic [`ACS_FEAT_IW-1:0]               feature_pick,
  input  wire logic                                  feat_en_wr,
  input  wire logic                                  feature_sequencing_on,
  input  wire logic                                  setup_phase_switch,
  input  wire logic                                  run_switch,
  input  wire logic                                  streaming,
  input  wire logic [`ACS_SET_W-1:0]                 set_pick,
  input  wire logic                                  set_store_cmd,
  input  wire logic                                  set_apply_cmd,
  input  wire logic                                  path_wr,
  input  wire logic [`ACS_SET_W-1:0]                 branch_pick,
  input  wire logic [`ACS_SRC_W-1:0]                 hop_event_source,
  input  wire logic [1:0]                            hop_event_qualifier,
  input  wire logic [`ACS_SET_W-1:0]                 following_set,
  input  wire logic                                  first_set_wr,
  input  wire logic [`ACS_SET_W-1:0]                 first_set,
  input  wire logic                                  feat_wr,
  input  wire logic [`ACS_FEAT_IW-1:0]               feat_idx,
  input  wire logic [`ACS_FEAT_W-1:0]                feat_val,
  input  wire logic                                  auto_wr,
  input  wire logic [`ACS_FEAT_N-1:0]                auto_val,
  input  wire logic [`ACS_SRC_N-1:0]                 hop_events_pin,
  output logic      [`ACS_FEAT_N*`ACS_FEAT_W-1:0]    live_cfg,
  output logic      [`ACS_FEAT_N-1:0]                auto_eff,
  output logic      [`ACS_FEAT_N-1:0]                lock_mask,
  output logic      [`ACS_FEAT_N-1:0]                seq_mask,
  output logic                                       set_ok_flag,
  output logic                                       setup_ok_flag,
  output logic                                       in_setup,
  output logic                                       running,
  output logic      [`ACS_SET_W-1:0]                 active_set,
  output logic      [`ACS_SET_W-1:0]                 start_set,
  output logic                                       cmd_reject
);

  localparam logic [`ACS_FEAT_N*`ACS_FEAT_N-1:0] DEP_MAP = `ACS_DEP_MAP;

  // ==========================================================
  // Helpers
  function automatic logic [`ACS_FEAT_N-1:0] dep_row(input int i);
    dep_row = DEP_MAP[i*`ACS_FEAT_N +: `ACS_FEAT_N];
  endfunction : dep_row

  // Returns {fixed, implied} for a given direct mask
  function automatic logic [2*`ACS_FEAT_N-1:0] classify(input logic [`ACS_FEAT_N-1:0] dir);
    logic [`ACS_FEAT_N-1:0] imp;
    logic [`ACS_FEAT_N-1:0] need;
    imp  = '0;
    need = '0;
    for (int i = 0; i < `ACS_FEAT_N; i++) begin
      imp[i] = !dir[i] && (|(dep_row(i) & dir));
    end
    for (int i = 0; i < `ACS_FEAT_N; i++) begin
      if (dir[i] || imp[i]) begin
        need = need | dep_row(i);
      end
    end
    classify = {need & ~dir & ~imp, imp};
  endfunction : classify

  function automatic logic qual_hit(input acs_pkg::acs_qual_type q, input logic s, input logic p);
    case (q)
      acs_pkg::ACS_Q_RISE: qual_hit = s && !p;
      acs_pkg::ACS_Q_FALL: qual_hit = !s && p;
      acs_pkg::ACS_Q_HIGH: qual_hit = s;
      default:             qual_hit = !s;
    endcase
  endfunction : qual_hit

  function automatic logic in_range(input acs_pkg::acs_vals_type v, input logic [`ACS_FEAT_N-1:0] m);
    in_range = 1'b1;
    for (int i = 0; i < `ACS_FEAT_N; i++) begin
      if (m[i] && (v[i] > `ACS_FEAT_MAX)) begin
        in_range = 1'b0;
      end
    end
  endfunction : in_range

  function automatic logic chain_ok(input logic [`ACS_SET_N-1:0] ok, input acs_pkg::acs_nexts_type nx,
                                    input acs_pkg::acs_idx_type start);
    chain_ok = ok[start];
    for (int j = 0; j < `ACS_SET_N; j++) begin
      if (ok[j] && !ok[nx[j]]) begin
        chain_ok = 1'b0;
      end
    end
  endfunction : chain_ok

  // ==========================================================
  // Trigger pin synchronisers
  logic [`ACS_SRC_N-1:0] pin_s1_q;
  logic [`ACS_SRC_N-1:0] pin_s2_q;
  logic [`ACS_SRC_N-1:0] pin_prev_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_s1_q   <= hop_events_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // ==========================================================
  // Set store
  acs_store_if sif ();

  acs_set_store u_store (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .st      (sif.store)
  );

  // ==========================================================
  // Control state
  acs_pkg::acs_state_type st_q,     st_d;
  acs_pkg::acs_vals_type  cfg_q,    cfg_d;
  logic [`ACS_FEAT_N-1:0] auto_q,   auto_d;
  logic [`ACS_FEAT_N-1:0] en_q,     en_d;
  logic [`ACS_FEAT_N-1:0] imp_q,    imp_d;
  logic [`ACS_FEAT_N-1:0] fix_q,    fix_d;
  logic [`ACS_SET_N-1:0]  valid_q,  valid_d;
  acs_pkg::acs_idx_type   start_q,  start_d;
  acs_pkg::acs_idx_type   act_q,    act_d;
  logic                   cfg_ok_q, cfg_ok_d;
  logic                   rej_q,    rej_d;
  logic                   sw_set_q;
  logic                   sw_run_q;
  logic [`ACS_FEAT_N-1:0] lock_q,   lock_d;
  logic [`ACS_FEAT_N-1:0] aeff_q,   aeff_d;
  logic                   sok_q,    sok_d;
  logic [`ACS_FEAT_N-1:0] seq_q,    seq_d;
  logic                   stp_q,    stp_d;
  logic                   run_q,    run_d;
  logic                   ld;
  logic [`ACS_FEAT_N-1:0] seq_now;
  logic [`ACS_FEAT_N-1:0] lock_now;
  logic [2*`ACS_FEAT_N-1:0] cls;
  logic                   hit;

  assign seq_now = en_q | imp_q | fix_q;
  assign cls     = classify(en_q);
  assign hit     = qual_hit(sif.act_path.qual, pin_s2_q[sif.act_path.src], pin_prev_q[sif.act_path.src]);

  always_comb begin
    case (st_q)
      acs_pkg::ACS_ST_RUN:   lock_now = seq_now;
      acs_pkg::ACS_ST_SETUP: lock_now = fix_q;
      default:               lock_now = '0;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    cfg_d         = cfg_q;
    auto_d        = auto_q;
    en_d          = en_q;
    imp_d         = imp_q;
    fix_d         = fix_q;
    valid_d       = valid_q;
    start_d       = start_q;
    act_d         = act_q;
    cfg_ok_d      = cfg_ok_q;
    rej_d         = 1'b0;
    ld            = 1'b0;
    sif.rd_idx    = set_pick;
    sif.save_we   = 1'b0;
    sif.save_idx  = set_pick;
    sif.save_vals = cfg_q;
    sif.path_we   = 1'b0;
    sif.path_idx  = set_pick;
    sif.path_wr   = '{src: hop_event_source, qual: acs_pkg::acs_qual_type'(hop_event_qualifier),
                      next: following_set};
    sif.act_idx   = act_q;
    sif.cur_vals  = cfg_q;
    sif.fix_mask  = fix_q;

    if (feat_wr) begin
      if (lock_now[feat_idx]) begin
        rej_d = 1'b1;
      end else begin
        cfg_d[feat_idx] = feat_val;
      end
    end
    if (auto_wr) begin
      if (st_q == acs_pkg::ACS_ST_RUN) begin
        rej_d = 1'b1;
      end else begin
        auto_d = auto_val & `ACS_AUTO_MASK;
      end
    end
    if (first_set_wr) begin
      if (st_q == acs_pkg::ACS_ST_RUN || !valid_q[first_set]) begin
        rej_d = 1'b1;
      end else begin
        start_d = first_set;
      end
    end
    if (path_wr) begin
      if (st_q == acs_pkg::ACS_ST_RUN || branch_pick != `ACS_PATH_ONLY || !valid_q[following_set]) begin
        rej_d = 1'b1;
      end else begin
        sif.path_we = 1'b1;
      end
    end
    if (set_apply_cmd) begin
      if (valid_q[set_pick]) begin
        ld = 1'b1;
      end else begin
        rej_d = 1'b1;
      end
    end

    case (st_q)
      acs_pkg::ACS_ST_IDLE: begin
        if (feat_en_wr) begin
          en_d[feature_pick] = feature_sequencing_on;
        end
        if (set_store_cmd) begin
          rej_d = 1'b1;
        end
        if (setup_phase_switch && !sw_set_q) begin
          st_d  = acs_pkg::ACS_ST_SETUP;
          imp_d = cls[`ACS_FEAT_N-1:0];
          fix_d = cls[2*`ACS_FEAT_N-1:`ACS_FEAT_N];
        end else if (run_switch && !sw_run_q) begin
          if (cfg_ok_q && !streaming) begin
            st_d       = acs_pkg::ACS_ST_RUN;
            act_d      = start_q;
            sif.rd_idx = start_q;
            ld         = 1'b1;
          end else begin
            rej_d = 1'b1;
          end
        end
      end
      acs_pkg::ACS_ST_SETUP: begin
        if (feat_en_wr) begin
          rej_d = 1'b1;
        end
        if (set_store_cmd) begin
          sif.save_we = 1'b1;
          for (int j = 0; j < `ACS_SET_N; j++) begin
            valid_d[j] = valid_q[j] && sif.fix_match[j];
          end
          valid_d[set_pick] = in_range(cfg_q, seq_now);
        end
        if (!setup_phase_switch) begin
          st_d     = acs_pkg::ACS_ST_IDLE;
          cfg_ok_d = chain_ok(valid_d, sif.all_next, start_q);
        end
      end
      acs_pkg::ACS_ST_RUN: begin
        if (feat_en_wr || set_store_cmd) begin
          rej_d = 1'b1;
        end
        if (!run_switch) begin
          st_d = acs_pkg::ACS_ST_IDLE;
        end else if (hit) begin
          act_d      = sif.act_path.next;
          sif.rd_idx = sif.act_path.next;
          ld         = 1'b1;
        end
      end
      default: begin
        st_d = acs_pkg::ACS_ST_IDLE;
      end
    endcase

    if (ld) begin
      for (int i = 0; i < `ACS_FEAT_N; i++) begin
        if (seq_now[i]) begin
          cfg_d[i] = sif.rd_vals[i];
        end
      end
    end
  end

  always_comb begin
    case (st_d)
      acs_pkg::ACS_ST_RUN:   lock_d = en_d | imp_d | fix_d;
      acs_pkg::ACS_ST_SETUP: lock_d = fix_d;
      default:               lock_d = '0;
    endcase
    aeff_d = (st_d == acs_pkg::ACS_ST_RUN) ? '0 : auto_d;
    sok_d  = valid_d[set_pick];
    seq_d  = en_d | imp_d | fix_d;
    stp_d  = (st_d == acs_pkg::ACS_ST_SETUP);
    run_d  = (st_d == acs_pkg::ACS_ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= acs_pkg::ACS_ST_IDLE;
      cfg_q    <= '{default: `ACS_FEAT_RST};
      auto_q   <= `ACS_MASK_RST;
      en_q     <= `ACS_MASK_RST;
      imp_q    <= `ACS_MASK_RST;
      fix_q    <= `ACS_MASK_RST;
      valid_q  <= `ACS_VALID_RST;
      start_q  <= `ACS_IDX_RST;
      act_q    <= `ACS_IDX_RST;
      cfg_ok_q <= 1'b0;
      rej_q    <= 1'b0;
      sw_set_q <= 1'b0;
      sw_run_q <= 1'b0;
      lock_q   <= `ACS_MASK_RST;
      aeff_q   <= `ACS_MASK_RST;
      sok_q    <= 1'b0;
      seq_q    <= `ACS_MASK_RST;
      stp_q    <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cfg_q    <= cfg_d;
      auto_q   <= auto_d;
      en_q     <= en_d;
      imp_q    <= imp_d;
      fix_q    <= fix_d;
      valid_q  <= valid_d;
      start_q  <= start_d;
      act_q    <= act_d;
      cfg_ok_q <= cfg_ok_d;
      rej_q    <= rej_d;
      sw_set_q <= setup_phase_switch;
      sw_run_q <= run_switch;
      lock_q   <= lock_d;
      aeff_q   <= aeff_d;
      sok_q    <= sok_d;
      seq_q    <= seq_d;
      stp_q    <= stp_d;
      run_q    <= run_d;
    end
  end

  // ==========================================================
  // Outputs
  assign live_cfg      = cfg_q;
  assign auto_eff      = aeff_q;
  assign lock_mask     = lock_q;
  assign seq_mask      = seq_q;
  assign set_ok_flag   = sok_q;
  assign setup_ok_flag = cfg_ok_q;
  assign in_setup      = stp_q;
  assign running       = run_q;
  assign active_set    = act_q;
  assign start_set     = start_q;
  assign cmd_reject    = rej_q;

endmodule : acs_sequencer

`default_nettype wire

// ### tb/acs_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_seq_properties (
  input wire logic                                sys_clk,
  input wire logic                                reset_n,
  input wire logic                                set_store_cmd,
  input wire logic                                path_wr,
  input wire logic [`ACS_SET_W-1:0]               branch_pick,
  input wire logic                                streaming,
  input wire logic [`ACS_FEAT_N*`ACS_FEAT_W-1:0]  live_cfg,
  input wire logic [`ACS_FEAT_N-1:0]              auto_eff,
  input wire logic [`ACS_FEAT_N-1:0]              lock_mask,
  input wire logic [`ACS_FEAT_N-1:0]              seq_mask,
  input wire logic                                setup_ok_flag,
  input wire logic                                in_setup,
  input wire logic                                running,
  input wire logic [`ACS_SET_W-1:0]               active_set,
  input wire logic [`ACS_SET_W-1:0]               start_set,
  input wire logic                                cmd_reject
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Locking
  non_seq_free_a: assert property ((lock_mask & ~seq_mask) == 4'h0)
    else $error("lock outside sequenced features");
  auto_forced_a: assert property (running |-> auto_eff == 4'h0)
    else $error("automatic feature on while running");
  run_lock_a: assert property (running |-> lock_mask == seq_mask)
    else $error("sequenced feature unlocked while running");
  idle_free_a: assert property (!in_setup && !running |-> lock_mask == 4'h0)
    else $error("lock left in idle");
  fixed_hold_a: assert property (in_setup && $past(in_setup) && $past(lock_mask[1]) |-> $stable(live_cfg[15:8]))
    else $error("fixed feature changed in setup");

  // ==========================================================
  // Run entry and refusals
  start_load_a: assert property ($rose(running) |-> active_set == start_set)
    else $error("run did not begin at start set");
  run_guard_a: assert property ($rose(running) |-> $past(setup_ok_flag) && !$past(streaming))
    else $error("run began without valid setup");
  phase_excl_a: assert property (!(in_setup && running))
    else $error("setup and run together");
  save_refuse_a: assert property (set_store_cmd && !in_setup |-> ##[1:2] cmd_reject)
    else $error("save outside setup not refused");
  path_refuse_a: assert property (path_wr && branch_pick != 3'h0 |-> ##[1:2] cmd_reject)
    else $error("second path not refused");
endmodule : acs_seq_properties

bind acs_sequencer acs_seq_properties i_acs_seq_properties (
  .sys_clk(sys_clk), .reset_n(reset_n), .set_store_cmd(set_store_cmd), .path_wr(path_wr),
  .branch_pick(branch_pick), .streaming(streaming), .live_cfg(live_cfg), .auto_eff(auto_eff),
  .lock_mask(lock_mask), .seq_mask(seq_mask), .setup_ok_flag(setup_ok_flag), .in_setup(in_setup),
  .running(running), .active_set(active_set), .start_set(start_set), .cmd_reject(cmd_reject)
);

`default_nettype wire

// ### tb/acs_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_trig_model (
  input  wire logic                    sys_clk,
  input  wire logic                    fire,
  output var  logic [`ACS_SRC_N-1:0]   pins
);
  int   hold_cnt = 0;
  logic hit;

  initial pins = '0;

  // ==========================================================
  // Event line on source 0, low between events
  always @(posedge sys_clk) begin
    hit = fire;
    #1;
    if (hit) hold_cnt = 4;
    pins[0] = (hold_cnt != 0);
    if (hold_cnt != 0) hold_cnt--;
  end
endmodule : acs_trig_model

`default_nettype wire

// ### tb/tb_acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module tb_acs_sequencer;
  logic        sys_clk, reset_n, feat_en_wr, feature_sequencing_on, setup_phase_switch, run_switch;
  logic        streaming, set_store_cmd, set_apply_cmd, path_wr, first_set_wr, feat_wr, auto_wr;
  logic        fire, rej_seen, in_setup, running, set_ok_flag, setup_ok_flag, cmd_reject;
  logic [1:0]  feature_pick, hop_event_source, hop_event_qualifier, feat_idx;
  logic [2:0]  set_pick, branch_pick, following_set, first_set, active_set, start_set;
  logic [3:0]  auto_val, hop_events_pin, auto_eff, lock_mask, seq_mask;
  logic [7:0]  feat_val;
  logic [31:0] live_cfg;
  int          errors, checks;

  acs_sequencer i_acs_sequencer (
    .sys_clk(sys_clk), .reset_n(reset_n), .feature_pick(feature_pick), .feat_en_wr(feat_en_wr),
    .feature_sequencing_on(feature_sequencing_on), .setup_phase_switch(setup_phase_switch),
    .run_switch(run_switch), .streaming(streaming), .set_pick(set_pick), .set_store_cmd(set_store_cmd),
    .set_apply_cmd(set_apply_cmd), .path_wr(path_wr), .branch_pick(branch_pick),
    .hop_event_source(hop_event_source), .hop_event_qualifier(hop_event_qualifier),
    .following_set(following_set), .first_set_wr(first_set_wr), .first_set(first_set), .feat_wr(feat_wr),
    .feat_idx(feat_idx), .feat_val(feat_val), .auto_wr(auto_wr), .auto_val(auto_val),
    .hop_events_pin(hop_events_pin), .live_cfg(live_cfg), .auto_eff(auto_eff), .lock_mask(lock_mask),
    .seq_mask(seq_mask), .set_ok_flag(set_ok_flag), .setup_ok_flag(setup_ok_flag), .in_setup(in_setup),
    .running(running), .active_set(active_set), .start_set(start_set), .cmd_reject(cmd_reject)
  );

  acs_trig_model i_acs_trig_model (.sys_clk(sys_clk), .fire(fire), .pins(hop_events_pin));

  // ==========================================================
  // Shared helpers
  always @(posedge sys_clk) if (cmd_reject === 1'b1) rej_seen <= 1'b1;

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic cmd();
    cyc(1);
    {feat_en_wr, set_store_cmd, set_apply_cmd, path_wr, first_set_wr, feat_wr, auto_wr} = '0;
    cyc(2);
  endtask : cmd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rej(input logic e);
    cmp(32'(rej_seen), 32'(e));
    rej_seen = 1'b0;
  endtask : rej

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic store(input logic [2:0] idx, input logic [7:0] val, input logic ok);
    feat_wr = 1; feat_idx = 2'h0; feat_val = val; cmd();
    set_pick = idx; set_store_cmd = 1; cmd();
    cmp(32'(set_ok_flag), 32'(ok));
  endtask : store

  task automatic path(input logic [2:0] idx, input logic [2:0] br, input logic [2:0] nxt, input logic [1:0] q,
                      input logic e);
    set_pick = idx; branch_pick = br; following_set = nxt; hop_event_source = 2'h0;
    hop_event_qualifier = q; path_wr = 1; cmd();
    rej(e);
  endtask : path

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    cmp(live_cfg, 32'h0);
    cmp(32'({in_setup, running, set_ok_flag, setup_ok_flag}), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    feat_wr = 1; feat_idx = 2'h1; feat_val = 8'h05; cmd();
    feature_pick = 2'h0; feature_sequencing_on = 1; feat_en_wr = 1; cmd(); rej(0);
    setup_phase_switch = 1; cyc(2);
    cmp(32'(in_setup), 32'h1);
    cmp(32'(lock_mask), 32'h2);
    cmp(32'(seq_mask), 32'h3);
    feat_wr = 1; feat_idx = 2'h1; feat_val = 8'h44; cmd(); rej(1);
    cmp(32'(live_cfg[15:8]), 32'h05);
    feat_en_wr = 1; cmd(); rej(1);
    $display("test config done");
  endtask : t_config

  task automatic t_sets();
    store(3'h0, 8'h10, 1);
    store(3'h7, 8'hf0, 1);
    store(3'h1, 8'h20, 1);
    store(3'h2, 8'hf1, 0);
    set_pick = 3'h0; cyc(2); cmp(32'(set_ok_flag), 32'h1);
    path(3'h0, 3'h0, 3'h1, 2'h1, 0);
    path(3'h1, 3'h0, 3'h0, 2'h0, 0);
    path(3'h1, 3'h1, 3'h0, 2'h0, 1);
    path(3'h0, 3'h0, 3'h2, 2'h0, 1);
    first_set = 3'h2; first_set_wr = 1; cmd(); rej(1);
    first_set = 3'h1; first_set_wr = 1; cmd(); rej(0);
    cmp(32'(start_set), 32'h1);
    setup_phase_switch = 0; cyc(2);
    cmp(32'({in_setup, setup_ok_flag}), 32'h1);
    $display("test sets done");
  endtask : t_sets

  task automatic t_run();
    auto_val = 4'hf; auto_wr = 1; cmd(); cmp(32'(auto_eff), 32'h5);
    streaming = 1; run_switch = 1; cyc(3); rej(1);
    cmp(32'(running), 32'h0);
    run_switch = 0; streaming = 0; cyc(2);
    run_switch = 1; cyc(2);
    cmp(32'({running, active_set}), 32'h9);
    cmp(32'(live_cfg[15:0]), 32'h0520);
    cmp(32'({auto_eff, lock_mask}), 32'h03);
    feat_wr = 1; feat_idx = 2'h0; feat_val = 8'h55; cmd(); rej(1);
    feat_wr = 1; feat_idx = 2'h2; feat_val = 8'h33; cmd(); rej(0);
    cmp(32'(live_cfg[23:16]), 32'h33);
    fire = 1; cyc(1); fire = 0; cyc(4);
    cmp(32'(active_set), 32'h0);
    cmp(32'(live_cfg[7:0]), 32'h10);
    cyc(4);
    cmp(32'({active_set, live_cfg[7:0]}), 32'h120);
    run_switch = 0; cyc(2);
    cmp(32'({running, live_cfg[7:0]}), 32'h020);
    $display("test run done");
  endtask : t_run

  task automatic t_apply();
    set_pick = 3'h0; set_apply_cmd = 1; cmd(); rej(0);
    cmp(32'(live_cfg[7:0]), 32'h10);
    set_pick = 3'h2; set_apply_cmd = 1; cmd(); rej(1);
    set_store_cmd = 1; cmd(); rej(1);
    feat_wr = 1; feat_idx = 2'h1; feat_val = 8'h06; cmd(); rej(0);
    setup_phase_switch = 1; cyc(2);
    store(3'h3, 8'h30, 1);
    set_pick = 3'h0; cyc(2); cmp(32'(set_ok_flag), 32'h0);
    $display("test apply done");
  endtask : t_apply

  // ==========================================================
  // Clock, sequence and watchdog
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    reset_n = 0; errors = 0; checks = 0; rej_seen = 0; fire = 0;
    {feat_en_wr, feature_sequencing_on, setup_phase_switch, run_switch, streaming} = '0;
    {set_store_cmd, set_apply_cmd, path_wr, first_set_wr, feat_wr, auto_wr} = '0;
    {feature_pick, hop_event_source, hop_event_qualifier, feat_idx, auto_val, feat_val} = '0;
    {set_pick, branch_pick, following_set, first_set} = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1;
    t_reset();
    t_config();
    t_sets();
    t_run();
    t_apply();
    print_verdict();
  end

  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule : tb_acs_sequencer

`default_nettype wire
